// >>> logic/mqf_dev.sv
/*
  Device end: 32 small queues, read queue select with first word
  fall through, 36-bit output word and per-queue partial reset.
  Assumes the host keeps link timing; one clock, sync reset.
*/
`timescale 1ns/100ps
module mqf_dev #(
   parameter logic [mqf_pkg::DEV_W-1:0] DEV_POS = 3'h0
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   mqf_link_if.dev link,
   output logic [mqf_pkg::NQ-1:0] queue_empty_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [mqf_pkg::NQ-1:0][mqf_pkg::DEPTH-1:0][mqf_pkg::DATA_W-1:0] mem;
      logic [mqf_pkg::NQ-1:0][mqf_pkg::PTR_W-1:0] wptr;
      logic [mqf_pkg::NQ-1:0][mqf_pkg::PTR_W-1:0] rptr;
      logic [mqf_pkg::QADDR_W-1:0] rq;
      logic rsel;
      logic [mqf_pkg::QADDR_W-1:0] wq;
      logic wsel;
      logic [1:0] fwft_cnt;
      logic [mqf_pkg::DATA_W-1:0] q;
      logic q_valid;
      logic q_drive_n;
      logic pkt_mode;
      logic [mqf_pkg::PROG_CNT_W-1:0] prog_cnt;
      logic prog_done_n;
      logic [mqf_pkg::NQ-1:0] empty;
   } mqf_dev_state_type;

   mqf_dev_state_type st_r;
   mqf_dev_state_type st_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic [mqf_pkg::QADDR_W-1:0] rd_addr_q;
   logic [mqf_pkg::DEV_W-1:0] rd_addr_dev;
   logic [mqf_pkg::QADDR_W-1:0] wr_addr_q;
   logic [mqf_pkg::DEV_W-1:0] wr_addr_dev;
   logic rd_empty;
   logic wr_full;
   logic [mqf_pkg::PTR_W-1:0] wr_fill;
   logic rd_go;
   logic rd_take;
   logic rd_unread;
   logic rd_fetch;

   assign rd_addr_q = link.rd_queue_addr[mqf_pkg::QADDR_W-1:0];
   assign rd_addr_dev = link.rd_queue_addr[mqf_pkg::DEV_LSB +: mqf_pkg::DEV_W];
   assign wr_addr_q = link.wr_queue_addr[mqf_pkg::QADDR_W-1:0];
   assign wr_addr_dev = link.wr_queue_addr[mqf_pkg::DEV_LSB +: mqf_pkg::DEV_W];
   assign rd_empty = st_r.rptr[st_r.rq] == st_r.wptr[st_r.rq];
   assign wr_fill = st_r.wptr[st_r.wq] - st_r.rptr[st_r.wq];
   assign wr_full = wr_fill == mqf_pkg::PTR_FULL;
   // Both enables low; a held word is never dropped unread
   assign rd_go = !link.rd_en_n && !link.out_en_n;
   // Fall through loads even with read enable high
   assign rd_take = st_r.rsel && ((st_r.fwft_cnt == mqf_pkg::FWFT_NOW) ||
      ((st_r.fwft_cnt == mqf_pkg::FWFT_IDLE) && (!st_r.q_valid || rd_go)));

   // ----------------------------------------
   // Select give-back
   // ----------------------------------------
   // A queue change must not eat a word the host never read
   assign rd_unread = st_r.rsel && st_r.q_valid && !rd_take;
   assign rd_fetch = rd_take && !rd_empty;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;

      // Programming sequence after reset
      if (st_r.prog_cnt != mqf_pkg::PROG_LAST) begin
         st_nxt.prog_cnt = st_r.prog_cnt + mqf_pkg::PROG_ONE;
      end else begin
         st_nxt.prog_done_n = 1'b0;
      end

      st_nxt.q_drive_n = link.out_en_n;

      // Fall-through countdown
      if (st_r.fwft_cnt != mqf_pkg::FWFT_IDLE) begin
         st_nxt.fwft_cnt = st_r.fwft_cnt - mqf_pkg::CNT2_ONE;
      end

      // Read side, old queue may still deliver on a select edge
      if (rd_take) begin
         if (!rd_empty) begin
            st_nxt.q = st_r.mem[st_r.rq][st_r.rptr[st_r.rq][mqf_pkg::IDX_W-1:0]];
            st_nxt.rptr[st_r.rq] = st_r.rptr[st_r.rq] + mqf_pkg::PTR_ONE;
            st_nxt.q_valid = 1'b1;
         end else begin
            st_nxt.q_valid = 1'b0;
         end
      end

      // Read queue selection
      if (link.rd_queue_sel_en) begin
         if (rd_unread) begin
            st_nxt.rptr[st_r.rq] = st_r.rptr[st_r.rq] - mqf_pkg::PTR_ONE;
         end else if (rd_fetch) begin
            // Word fetched on this edge is never shown
            st_nxt.rptr[st_r.rq] = st_r.rptr[st_r.rq];
         end
         if (rd_addr_dev == DEV_POS) begin
            st_nxt.rq = rd_addr_q;
            st_nxt.rsel = 1'b1;
            st_nxt.fwft_cnt = mqf_pkg::FWFT_LOAD;
            st_nxt.q_valid = 1'b0;
         end else begin
            // Another expanded device answers
            st_nxt.rsel = 1'b0;
            st_nxt.fwft_cnt = mqf_pkg::FWFT_IDLE;
            st_nxt.q_valid = 1'b0;
         end
      end

      // Write queue selection
      if (link.wr_queue_sel_en) begin
         st_nxt.wsel = wr_addr_dev == DEV_POS;
         st_nxt.wq = wr_addr_q;
      end

      // Write side, full queue drops the word
      if (!link.wr_en_n && st_r.wsel && !wr_full) begin
         st_nxt.mem[st_r.wq][st_r.wptr[st_r.wq][mqf_pkg::IDX_W-1:0]] = link.wr_data;
         st_nxt.wptr[st_r.wq] = st_r.wptr[st_r.wq] + mqf_pkg::PTR_ONE;
      end

      // Partial reset wins over a same-cycle read or write
      if (!link.queue_clear_n && st_r.wsel) begin
         // Data words left in memory; pointers reset, held word of this queue drops
         st_nxt.wptr[st_r.wq] = mqf_pkg::PTR_RST;
         st_nxt.rptr[st_r.wq] = mqf_pkg::PTR_RST;
         if (st_r.rsel && (st_r.rq == st_r.wq)) begin
            st_nxt.q_valid = 1'b0;
            st_nxt.fwft_cnt = mqf_pkg::FWFT_IDLE;
         end
      end

      for (int i = 0; i < mqf_pkg::NQ; i++) begin
         st_nxt.empty[i] = st_nxt.wptr[i] == st_nxt.rptr[i];
      end

      // Synchronous master reset; memory contents kept
      if (srst_in) begin
         st_nxt.wptr = '0;
         st_nxt.rptr = '0;
         st_nxt.rq = '0;
         st_nxt.rsel = 1'b0;
         st_nxt.wq = '0;
         st_nxt.wsel = 1'b0;
         st_nxt.fwft_cnt = mqf_pkg::FWFT_IDLE;
         st_nxt.q = '0;
         st_nxt.q_valid = 1'b0;
         st_nxt.q_drive_n = 1'b1;
         // Width is fixed at 36 both ways, so selection is legal
         st_nxt.pkt_mode = link.packet_mode_sel &&
            (mqf_pkg::DATA_W == mqf_pkg::PKT_DATA_W);
         st_nxt.prog_cnt = mqf_pkg::PROG_ZERO;
         st_nxt.prog_done_n = 1'b1;
         st_nxt.empty = '1;
      end
   end

   // ----------------------------------------
   // Register
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      st_r <= st_nxt;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Bits 35:32 pass as written; in packet mode they are markers
   assign link.q_data = st_r.q;
   assign link.packet_mode_act = st_r.pkt_mode;
   assign link.q_drive_n = st_r.q_drive_n;
   assign link.q_valid = st_r.q_valid;
   assign link.serial_prog_done_n = st_r.prog_done_n;
   assign queue_empty_out = st_r.empty;

endmodule

// >>> logic/mqf_pkg.sv
/*
  Constants and types shared by both ends of the multi-queue read link.
  Assumes one clock for read and write ports; no imports anywhere.
*/
package mqf_pkg;
   // ----------------------------------------
   // Widths and sizes
   // ----------------------------------------
   localparam int DATA_W = 36;
   localparam int ADDR_W = 8;
   localparam int QADDR_W = 5;
   localparam int DEV_LSB = 5;
   localparam int DEV_W = 3;
   localparam int NQ = 32;
   localparam int DEPTH = 8;
   localparam int IDX_W = 3;
   localparam int PTR_W = 4;
   localparam int MARK_LSB = 32;
   localparam int MARK_W = 4;
   localparam int PKT_DATA_W = 36;

   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [PTR_W-1:0] PTR_RST = 4'h0;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
   localparam logic [PTR_W-1:0] PTR_FULL = 4'h8;
   localparam logic [1:0] FWFT_LOAD = 2'h2;
   localparam logic [1:0] FWFT_NOW = 2'h1;
   localparam logic [1:0] FWFT_IDLE = 2'h0;
   localparam logic [1:0] SETUP_WAIT = 2'h2;
   localparam logic [1:0] CNT2_ZERO = 2'h0;
   localparam logic [1:0] CNT2_ONE = 2'h1;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int PROG_TIME_NS = 400;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROG_CNT_W = 6;
   localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES);
   localparam logic [PROG_CNT_W-1:0] PROG_ZERO = 6'h00;
   localparam logic [PROG_CNT_W-1:0] PROG_ONE = 6'h01;

   // ----------------------------------------
   // Host user orders
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_SEL_RD,
      OP_SEL_WR,
      OP_WRITE,
      OP_READ,
      OP_CLEAR,
      OP_QUAD
   } mqf_op_type;
endpackage

// >>> logic/mqf_link_if.sv
/*
  Wires between the multi-queue device end and its host controller.
  Assumes both ends run on the same clock; the bench ties modports.
*/
`timescale 1ns/100ps
interface mqf_link_if;
   logic [mqf_pkg::ADDR_W-1:0] rd_queue_addr;
   logic rd_queue_sel_en;
   logic [mqf_pkg::ADDR_W-1:0] wr_queue_addr;
   logic wr_queue_sel_en;
   logic wr_en_n;
   logic [mqf_pkg::DATA_W-1:0] wr_data;
   logic rd_en_n;
   logic out_en_n;
   logic queue_clear_n;
   logic empty_flag_quad_strobe;
   logic packet_mode_sel;
   logic [mqf_pkg::DATA_W-1:0] q_data;
   logic q_drive_n;
   logic q_valid;
   logic serial_prog_done_n;
   logic packet_mode_act;

   modport dev (
      input rd_queue_addr, rd_queue_sel_en, wr_queue_addr, wr_queue_sel_en,
      input wr_en_n, wr_data, rd_en_n, out_en_n, queue_clear_n,
      input empty_flag_quad_strobe, packet_mode_sel,
      output q_data, q_drive_n, q_valid, serial_prog_done_n, packet_mode_act
   );

   modport host (
      output rd_queue_addr, rd_queue_sel_en, wr_queue_addr, wr_queue_sel_en,
      output wr_en_n, wr_data, rd_en_n, out_en_n, queue_clear_n,
      output empty_flag_quad_strobe, packet_mode_sel,
      input q_data, q_drive_n, q_valid, serial_prog_done_n, packet_mode_act
   );
endinterface

// >>> logic/mqf_host.sv
/*
  Host controller end: turns user orders into link cycles for the
  multi-queue device. Assumes the device shares ref_clk_in.
*/
`timescale 1ns/100ps
module mqf_host (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   mqf_link_if.host link,
   input wire logic user_valid_in,
   input wire mqf_pkg::mqf_op_type user_op_in,
   input wire logic [mqf_pkg::ADDR_W-1:0] user_addr_in,
   input wire logic [mqf_pkg::DATA_W-1:0] user_data_in,
   input wire logic user_pkt_mode_in,
   output logic user_busy_out,
   output logic [mqf_pkg::DATA_W-1:0] user_word_out,
   output logic user_word_valid_out
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [2:0] {
      H_PROG,
      H_IDLE,
      H_CLR_WAIT,
      H_CLR_PULSE
   } mqf_host_st_type;

   typedef struct packed {
      mqf_host_st_type st;
      logic [1:0] wait_cnt;
      logic [mqf_pkg::ADDR_W-1:0] rd_addr;
      logic rd_sel_en;
      logic [mqf_pkg::ADDR_W-1:0] wr_addr;
      logic wr_sel_en;
      logic wr_en_n;
      logic [mqf_pkg::DATA_W-1:0] wr_data;
      logic rd_en_n;
      logic out_en_n;
      logic clear_n;
      logic strobe;
      logic pkt_sel;
      logic busy;
      logic [mqf_pkg::DATA_W-1:0] word;
      logic word_valid;
   } mqf_host_state_type;

   mqf_host_state_type h_r;
   mqf_host_state_type h_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      h_nxt = h_r;
      // Enables other than out_en_n are single-cycle unless reasserted
      h_nxt.rd_sel_en = 1'b0;
      h_nxt.wr_sel_en = 1'b0;
      h_nxt.wr_en_n = 1'b1;
      h_nxt.rd_en_n = 1'b1;
      h_nxt.clear_n = 1'b1;
      h_nxt.strobe = 1'b0;
      h_nxt.pkt_sel = user_pkt_mode_in;
      h_nxt.word = link.q_data;
      h_nxt.word_valid = link.q_valid && !link.q_drive_n;

      unique case (h_r.st)
         H_PROG: begin
            // No queue select until device programming ends
            if (!link.serial_prog_done_n) begin
               h_nxt.st = H_IDLE;
               h_nxt.out_en_n = 1'b0;
            end
         end
         H_IDLE: begin
            if (user_valid_in) begin
               unique case (user_op_in)
                  mqf_pkg::OP_SEL_RD: begin
                     // One order per cycle keeps this apart from the strobe
                     h_nxt.rd_sel_en = 1'b1;
                     h_nxt.rd_addr = user_addr_in;
                  end
                  mqf_pkg::OP_SEL_WR: begin
                     h_nxt.wr_sel_en = 1'b1;
                     h_nxt.wr_addr = user_addr_in;
                  end
                  mqf_pkg::OP_WRITE: begin
                     h_nxt.wr_en_n = 1'b0;
                     h_nxt.wr_data = user_data_in;
                  end
                  mqf_pkg::OP_READ: begin
                     h_nxt.rd_en_n = 1'b0;
                  end
                  mqf_pkg::OP_CLEAR: begin
                     // Same queue on both ports before the clear
                     h_nxt.rd_sel_en = 1'b1;
                     h_nxt.wr_sel_en = 1'b1;
                     h_nxt.rd_addr = user_addr_in;
                     h_nxt.wr_addr = user_addr_in;
                     h_nxt.wait_cnt = mqf_pkg::SETUP_WAIT;
                     h_nxt.st = H_CLR_WAIT;
                  end
                  mqf_pkg::OP_QUAD: begin
                     h_nxt.strobe = 1'b1;
                     h_nxt.rd_addr = user_addr_in;
                  end
                  default: begin
                     h_nxt.st = H_IDLE;
                  end
               endcase
            end
         end
         H_CLR_WAIT: begin
            h_nxt.wait_cnt = h_r.wait_cnt - mqf_pkg::CNT2_ONE;
            if (h_r.wait_cnt == mqf_pkg::CNT2_ONE) begin
               h_nxt.st = H_CLR_PULSE;
               h_nxt.clear_n = 1'b0;
            end
         end
         H_CLR_PULSE: begin
            h_nxt.st = H_IDLE;
         end
      endcase
      h_nxt.busy = h_nxt.st != H_IDLE;

      if (srst_in) begin
         h_nxt = '0;
         h_nxt.st = H_PROG;
         h_nxt.wr_en_n = 1'b1;
         h_nxt.rd_en_n = 1'b1;
         h_nxt.out_en_n = 1'b1;
         h_nxt.clear_n = 1'b1;
         h_nxt.busy = 1'b1;
         h_nxt.pkt_sel = user_pkt_mode_in;
      end
   end

   // ----------------------------------------
   // Register
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      h_r <= h_nxt;
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign link.rd_queue_addr = h_r.rd_addr;
   assign link.rd_queue_sel_en = h_r.rd_sel_en;
   assign link.wr_queue_addr = h_r.wr_addr;
   assign link.wr_queue_sel_en = h_r.wr_sel_en;
   assign link.wr_en_n = h_r.wr_en_n;
   assign link.wr_data = h_r.wr_data;
   assign link.rd_en_n = h_r.rd_en_n;
   assign link.out_en_n = h_r.out_en_n;
   assign link.queue_clear_n = h_r.clear_n;
   assign link.empty_flag_quad_strobe = h_r.strobe;
   assign link.packet_mode_sel = h_r.pkt_sel;
   assign user_busy_out = h_r.busy;
   assign user_word_out = h_r.word;
   assign user_word_valid_out = h_r.word_valid;

endmodule

// >>> bench/mqf_assertions.sv
/*
  Checker on the link between host and device ends.
  Assumes one clock and the sync high reset of both ends.
*/
`timescale 1ns/100ps
module mqf_link_assertions #(
   parameter logic [mqf_pkg::DEV_W-1:0] DEV_POS = 3'h0
) (
   input wire logic ref_clk_in,
   input wire logic srst_in,
   input wire logic [mqf_pkg::ADDR_W-1:0] rd_queue_addr,
   input wire logic rd_queue_sel_en,
   input wire logic [mqf_pkg::ADDR_W-1:0] wr_queue_addr,
   input wire logic wr_queue_sel_en,
   input wire logic rd_en_n,
   input wire logic out_en_n,
   input wire logic queue_clear_n,
   input wire logic empty_flag_quad_strobe,
   input wire logic [mqf_pkg::DATA_W-1:0] q_data,
   input wire logic q_drive_n,
   input wire logic q_valid,
   input wire logic serial_prog_done_n,
   input wire logic packet_mode_act
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   property p_sel_after_prep;
      rd_queue_sel_en |-> !serial_prog_done_n;
   endproperty
   a_sel_after_prep: assert property (p_sel_after_prep) else $error("select before programming done");
   property p_sel_no_strobe;
      !(rd_queue_sel_en && empty_flag_quad_strobe);
   endproperty
   a_sel_no_strobe: assert property (p_sel_no_strobe) else $error("select with quadrant strobe");
   property p_sel_short;
      rd_queue_sel_en ##1 rd_queue_sel_en |=> !rd_queue_sel_en;
   endproperty
   a_sel_short: assert property (p_sel_short) else $error("select enable held high");
   property p_clear_prep;
      !queue_clear_n |-> $past(rd_queue_sel_en, 2) && $past(wr_queue_sel_en, 2) && rd_queue_addr == wr_queue_addr;
   endproperty
   a_clear_prep: assert property (p_clear_prep) else $error("clear without both ports selected");
   property p_clear_pulse;
      !queue_clear_n |=> queue_clear_n;
   endproperty
   a_clear_pulse: assert property (p_clear_pulse) else $error("clear longer than one cycle");
   property p_clear_empties;
      !queue_clear_n |=> !q_valid;
   endproperty
   a_clear_empties: assert property (p_clear_empties) else $error("word left after clear");
   property p_sel_drops;
      rd_queue_sel_en |=> !q_valid [*2];
   endproperty
   a_sel_drops: assert property (p_sel_drops) else $error("word shown too early after select");
   property p_other_dev;
      rd_queue_sel_en && rd_queue_addr[7:5] != DEV_POS |=> !q_valid [*4];
   endproperty
   a_other_dev: assert property (p_other_dev) else $error("answered other device address");
   property p_hold_word;
      q_valid && (rd_en_n || out_en_n) && !rd_queue_sel_en && queue_clear_n |=> $stable(q_data);
   endproperty
   a_hold_word: assert property (p_hold_word) else $error("word moved without read");
   property p_drive;
      1'b1 |=> q_drive_n == $past(out_en_n);
   endproperty
   a_drive: assert property (p_drive) else $error("output drive not following enable");
   property p_pkt_fixed;
      !$past(srst_in) |-> $stable(packet_mode_act);
   endproperty
   a_pkt_fixed: assert property (p_pkt_fixed) else $error("packet mode changed outside reset");

   // ----------------------------------------
   // Covers
   // ----------------------------------------
   c_sel_word: cover property (rd_queue_sel_en ##3 q_valid);
   c_clear: cover property (!queue_clear_n);
   c_pop: cover property (q_valid && !rd_en_n && !out_en_n);
endmodule

// >>> bench/mqf_tb_top.sv
/*
  Bench: host and device ends face each other; a queue model checks
  words, empties and packet mode. Assumes package and link compiled.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_total++; \
$display("mismatch %s exp %h got %h", nm, ex, got); end end
module multi_queue_read_select_partial_reset_tb_top;
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic user_valid_in = 1'b0;
   mqf_pkg::mqf_op_type user_op_in = mqf_pkg::OP_SEL_RD;
   logic [7:0] user_addr_in = 8'h00;
   logic [35:0] user_data_in = 36'h0;
   logic user_pkt_mode_in = 1'b0;
   logic user_busy_out;
   logic [35:0] user_word_out;
   logic user_word_valid_out;
   logic [31:0] queue_empty_out;
   logic [35:0] mdl[32][$];
   int err_total = 0;
   int samples_checked = 0;
   int cyc = 0;
   int rq = -1;

   // ----------------------------------------
   // Design and checker
   // ----------------------------------------
   mqf_link_if link ();
   mqf_dev #(.DEV_POS(3'h0)) i_mqf_dev (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .link(link),
      .queue_empty_out(queue_empty_out));
   mqf_host i_mqf_host (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .link(link),
      .user_valid_in(user_valid_in), .user_op_in(user_op_in), .user_addr_in(user_addr_in),
      .user_data_in(user_data_in), .user_pkt_mode_in(user_pkt_mode_in), .user_busy_out(user_busy_out),
      .user_word_out(user_word_out), .user_word_valid_out(user_word_valid_out));
   mqf_link_assertions #(.DEV_POS(3'h0)) u_chk (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
      .rd_queue_addr(link.rd_queue_addr), .rd_queue_sel_en(link.rd_queue_sel_en),
      .wr_queue_addr(link.wr_queue_addr), .wr_queue_sel_en(link.wr_queue_sel_en), .rd_en_n(link.rd_en_n),
      .out_en_n(link.out_en_n), .queue_clear_n(link.queue_clear_n),
      .empty_flag_quad_strobe(link.empty_flag_quad_strobe), .q_data(link.q_data), .q_drive_n(link.q_drive_n),
      .q_valid(link.q_valid), .serial_prog_done_n(link.serial_prog_done_n),
      .packet_mode_act(link.packet_mode_act));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic stop_test();
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge ref_clk_in);
      #1;
   endtask

   // Waits out busy so an order is never dropped silently
   task automatic order(input mqf_pkg::mqf_op_type op, input logic [7:0] a, input logic [35:0] d);
      int n;
      n = 0;
      while (user_busy_out !== 1'b0 && n < 100) begin
         step();
         n++;
      end
      if (n == 100) err_total++;
      @(posedge ref_clk_in);
      user_valid_in <= 1'b1;
      user_op_in <= op;
      user_addr_in <= a;
      user_data_in <= d;
      @(posedge ref_clk_in);
      user_valid_in <= 1'b0;
      repeat (8) step();
   endtask

   function automatic logic [35:0] rnd();
      return {4'($urandom), 32'($urandom)};
   endfunction

   task automatic chk_out();
      logic ev;
      ev = (rq >= 0) ? (mdl[rq].size() != 0) : 1'b0;
      `CHK("q_valid", ev, link.q_valid)
      if (ev) `CHK("q_data", mdl[rq][0], link.q_data)
      `CHK("word_valid", ev, user_word_valid_out)
      if (ev) `CHK("word", mdl[rq][0], user_word_out)
   endtask

   task automatic wr(input int q, input logic [35:0] d);
      order(mqf_pkg::OP_SEL_WR, 8'(q), 36'h0);
      order(mqf_pkg::OP_WRITE, 8'h00, d);
      if (mdl[q].size() < 8) mdl[q].push_back(d);
   endtask

   task automatic sel(input int q, input logic [2:0] dv);
      order(mqf_pkg::OP_SEL_RD, {dv, 5'(q)}, 36'h0);
      rq = (dv == 3'h0) ? q : -1;
      chk_out();
   endtask

   task automatic rd();
      order(mqf_pkg::OP_READ, 8'h00, 36'h0);
      if (rq >= 0 && mdl[rq].size() != 0) void'(mdl[rq].pop_front());
      chk_out();
   endtask

   // ----------------------------------------
   // Clock, timeout and sequence
   // ----------------------------------------
   initial begin
      forever #10 ref_clk_in = ~ref_clk_in;
   end

   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(32'h3e5173f0));
      user_pkt_mode_in <= 1'($urandom);
      repeat (20) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      step();
      `CHK("pkt_act", user_pkt_mode_in, link.packet_mode_act)
      // Nine writes to one queue; the last must be dropped
      for (int i = 0; i < 9; i++) wr(0, rnd());
      `CHK("prog_done", 1'b0, link.serial_prog_done_n)
      wr(5, rnd());
      wr(5, rnd());
      wr(31, rnd());
      sel(0, 3'h0);
      for (int i = 0; i < 9; i++) rd();
      sel(31, 3'h1);
      rd();
      sel(5, 3'h0);
      order(mqf_pkg::OP_CLEAR, 8'h05, 36'h0);
      mdl[5].delete();
      rq = 5;
      chk_out();
      `CHK("empty", 3'b101, {queue_empty_out[5], queue_empty_out[31], queue_empty_out[7]})
      sel(31, 3'h0);
      order(mqf_pkg::OP_QUAD, 8'h02, 36'h0);
      for (int i = 0; i < 30; i++) begin
         case ($urandom % 3)
            0: begin
               if (mdl[i % 4].size() < 7) wr(i % 4, rnd());
            end
            1: rd();
            default: sel(int'($urandom % 4), 3'h0);
         endcase
      end
      stop_test();
   end
endmodule
